// ===== hdl/ssp_baud.sv
// Reload down-counter that paces the master shift clock
`timescale 1ns/10ps
`default_nettype none
module ssp_baud (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_run,
	input wire logic [15:0] i_reload,
	// Half-period tick
	output logic o_tick
);
	logic [15:0] cnt_reg;

	// One tick every reload+1 cycles, two ticks per shift clock period
	always_ff @(posedge i_core_clk or posedge i_rst) begin // see (RULE17) (RULE18)
		if (i_rst) begin
			cnt_reg <= 16'h0000;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			cnt_reg <= i_reload;
			o_tick <= 1'b0;
		end else if (cnt_reg == 16'h0000) begin
			cnt_reg <= i_reload;
			o_tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
			o_tick <= 1'b0;
		end
	end
endmodule // ssp_baud
`default_nettype wire

// ===== hdl/ssp_pkg.sv
// Constants, register map and types for the synchronous serial shift port
package ssp_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BAUD = 8'h04;
	localparam logic [7:0] ADDR_TX = 8'h08;
	localparam logic [7:0] ADDR_RX = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	// Control word, configuration view
	localparam int FLD_WSEL_LSB = 0;
	localparam int FLD_WSEL_MSB = 3;
	localparam int FLD_MSB_FIRST = 4;
	localparam int FLD_EDGE_SEL = 5;
	localparam int FLD_IDLE_LVL = 6;
	localparam int FLD_MASTER = 7;
	localparam int FLD_ENABLE = 15;
	// Control word, status view
	localparam int FLD_CNT_LSB = 0;
	localparam int FLD_CNT_MSB = 3;
	localparam int FLD_ERR_TX = 8;
	localparam int FLD_ERR_RX = 9;
	localparam int FLD_ERR_PH = 10;
	localparam int FLD_ERR_BD = 11;
	localparam int FLD_BUSY = 12;
	// Buffer status word
	localparam int FLD_TB_FULL = 0;
	localparam int FLD_RB_FULL = 1;
	localparam int FLD_ST_BUSY = 2;
	// Reset values
	localparam logic [3:0] WSEL_RST = 4'h7;
	localparam logic [15:0] BAUD_RST = 16'h0009;
	// Word length limits
	localparam logic [4:0] WLEN_MIN = 5'h02;
	localparam logic [4:0] WLEN_MAX = 5'h10;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SSP_IDLE, SSP_LOADED, SSP_SHIFT} ssp_state_t;
endpackage

// ===== hdl/ssp_port.sv
// Synchronous serial shift port with AXI4-Lite register access
// Behaviour
// (RULE1) Word length programmable from 2 to 16 bits per frame.
// (RULE2) Bit order select: 0 shifts LSB first, 1 shifts MSB first.
// (RULE3) Idle level field sets shift clock rest level; idle-high leads falling.
// (RULE4) Edge select picks shift-out edge; receive latches on the other edge.
// (RULE5) Disabled: control word shows configuration; enabled: shows status flags.
// (RULE6) Pending transmit word enters shift register once it is empty.
// (RULE7) Master starts right after loading; slave waits for external clock.
// (RULE8) Transfer start sets busy flag and pulses transmit-empty interrupt; a slave start in the same cycle as its load gives no pulse.
// (RULE9) After last bit, shift data goes to receive buffer; pulse rx-full.
// (RULE10) No pending word at frame end: busy clears when receive buffer loads.
// (RULE11) Software never writes the busy flag; hardware alone owns it.
// (RULE12) Transfer starts at least two cycles after transmit buffer write.
// (RULE13) Software tracks transfers by the interrupt pulses, not busy polling.
// (RULE14) Same number of bits received as transmitted each frame.
// (RULE15) Buffers are right-aligned, frame LSB at bit 0.
// (RULE16) Transmit bits above width ignored; receive bits above width invalid.
// (RULE17) Master clock comes from a 16-bit baud-rate generator.
// (RULE18) Baud range spans reload 0 to 65535 of the module clock.
// (RULE19) Only the master drives the shift clock; slaves take it as input.
// (RULE20) System setup makes exactly one master, all others slaves.
// (RULE21) Receive, phase, baud and transmit errors raise an interrupt pulse.
// (RULE22) Reload before frame end continues with no idle gap.
// (RULE23) Slave drives its first bit as soon as data enters shift register.
`timescale 1ns/10ps
`default_nettype none
module ssp_port
	import ssp_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// AXI4-Lite write address
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// Master out line
	input wire logic i_master_out_line,
	output logic o_master_out_line,
	output logic o_master_out_line_oe,
	// Master in line
	input wire logic i_master_in_line,
	output logic o_master_in_line,
	output logic o_master_in_line_oe,
	// Shift clock
	input wire logic i_shift_clock_pin,
	output logic o_master_shift_clock_out,
	output logic o_master_shift_clock_out_oe,
	// Event pulses
	output logic o_tx_empty_irq,
	output logic o_rx_full_irq,
	output logic o_err_irq,
	output logic o_xfer_done_irq
);
	// Configuration
	logic en_reg, ms_reg, msb_reg, ph_reg, po_reg;
	logic [3:0] wsel_reg;
	logic [15:0] baud_reg;
	// Buffers
	logic [15:0] tb_reg, rb_reg;
	logic tb_full_reg, tb_full_d_reg, rb_full_reg;
	// Errors
	logic err_tx_reg, err_rx_reg, err_ph_reg, err_bd_reg;
	// Shift engine
	ssp_state_t state_reg;
	logic [15:0] sr_reg, rx_reg;
	logic [4:0] cnt_reg;
	logic sck_reg, out_reg, pre_reg, busy_reg;
	// Pin synchronisers and edge history
	logic [2:0] sync1_reg, sync2_reg;
	logic sck_prev_reg, din_prev_reg, edge_d_reg;
	// AXI state
	logic aw_hold_reg, w_hold_reg;
	logic [7:0] awaddr_reg;
	logic [15:0] wdata_reg;
	logic [1:0] wstrb_reg;

	function automatic logic first_bit(input logic [15:0] v, input logic msb,
		input logic [4:0] w);
		return msb ? v[4'(w - 5'h01)] : v[0]; // see (RULE2) (RULE16)
	endfunction

	function automatic logic [15:0] shift_tx(input logic [15:0] v, input logic msb);
		return msb ? {v[14:0], 1'b0} : {1'b0, v[15:1]};
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	// Word length, field value 0 clamps to the minimum
	logic [4:0] wlen;
	assign wlen = (wsel_reg == 4'h0) ? WLEN_MIN : {1'b0, wsel_reg} + 5'h01; // see (RULE1)

	// Two-stage synchronisers: shift clock, master in, master out
	logic [2:0] pin_raw;
	assign pin_raw = {i_master_out_line, i_master_in_line, i_shift_clock_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	logic s_sck, din;
	assign s_sck = sync2_reg[0];
	assign din = ms_reg ? sync2_reg[1] : sync2_reg[2];

	// Baud generator
	logic tick;
	ssp_baud u_baud (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_run(en_reg && ms_reg), // see (RULE17)
		.i_reload(baud_reg),
		.o_tick(tick)
	);

	// Edge events
	logic m_edge, s_edge, ev_lead, ev_trail, latch_evt, shift_evt, act;
	assign m_edge = ms_reg && tick && (state_reg == SSP_SHIFT);
	assign s_edge = !ms_reg && (s_sck != sck_prev_reg);
	// Leading edge leaves the idle level
	assign ev_lead = ms_reg ? (m_edge && sck_reg == po_reg)
		: (s_edge && s_sck != po_reg); // see (RULE3)
	assign ev_trail = ms_reg ? (m_edge && sck_reg != po_reg)
		: (s_edge && s_sck == po_reg);
	assign shift_evt = ph_reg ? ev_lead : ev_trail; // see (RULE4)
	assign latch_evt = ph_reg ? ev_trail : ev_lead;
	assign act = ms_reg || (state_reg == SSP_SHIFT) || ev_lead;

	// Receive assembly and frame completion
	logic [15:0] rx_in, rx_fin, rx_align;
	logic [4:0] cnt_eff;
	logic done, load_ok, load, start_s, tx_err_evt, tx_empty_evt;
	assign rx_in = msb_reg ? {rx_reg[14:0], din} : {din, rx_reg[15:1]};
	assign rx_fin = latch_evt ? rx_in : rx_reg;
	assign rx_align = msb_reg ? rx_fin : rx_fin >> (WLEN_MAX - wlen); // see (RULE15)
	assign cnt_eff = ph_reg ? cnt_reg + 5'h01 : cnt_reg;
	assign done = act && ev_trail && (state_reg == SSP_SHIFT) && (cnt_eff == wlen); // see (RULE14)
	// Word becomes loadable only one cycle after it is seen
	assign load_ok = tb_full_reg && tb_full_d_reg; // see (RULE12)
	assign load = load_ok && (done || (state_reg == SSP_IDLE && (!ms_reg || tick))); // see (RULE6)
	assign start_s = !ms_reg && (state_reg != SSP_SHIFT) && ev_lead; // see (RULE7)
	assign tx_err_evt = start_s && (state_reg == SSP_IDLE) && !load;
	assign tx_empty_evt = (load && (ms_reg || done)) || (start_s && state_reg == SSP_LOADED); // see (RULE8)

	// AXI write path
	logic wr_do, wr_ctrl, wr_baud, wr_tx, wr_hit;
	assign wr_do = aw_hold_reg && w_hold_reg && !o_s_axi_bvalid;
	assign wr_ctrl = wr_do && (awaddr_reg == ADDR_CTRL);
	assign wr_baud = wr_do && (awaddr_reg == ADDR_BAUD);
	assign wr_tx = wr_do && (awaddr_reg == ADDR_TX);
	assign wr_hit = wr_ctrl || wr_baud || wr_tx || (awaddr_reg == ADDR_RX)
		|| (awaddr_reg == ADDR_STAT);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_awready <= 1'b0;
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
		end else if (i_s_axi_awvalid && o_s_axi_awready) begin
			o_s_axi_awready <= 1'b0;
			aw_hold_reg <= 1'b1;
			awaddr_reg <= {i_s_axi_awaddr[7:2], 2'b00};
		end else begin
			if (wr_do) aw_hold_reg <= 1'b0;
			o_s_axi_awready <= !aw_hold_reg && !o_s_axi_bvalid;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_wready <= 1'b0;
			w_hold_reg <= 1'b0;
			wdata_reg <= 16'h0000;
			wstrb_reg <= 2'h0;
		end else if (i_s_axi_wvalid && o_s_axi_wready) begin
			o_s_axi_wready <= 1'b0;
			w_hold_reg <= 1'b1;
			wdata_reg <= i_s_axi_wdata[15:0];
			wstrb_reg <= i_s_axi_wstrb[1:0];
		end else begin
			if (wr_do) w_hold_reg <= 1'b0;
			o_s_axi_wready <= !w_hold_reg && !o_s_axi_bvalid;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= RESP_OKAY;
		end else if (wr_do) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration is frozen while enabled except for the enable bit
	logic [15:0] ctrl_wd;
	assign ctrl_wd = merge(16'h0000, wdata_reg, wstrb_reg);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			en_reg <= 1'b0;
			ms_reg <= 1'b0;
			msb_reg <= 1'b0;
			ph_reg <= 1'b0;
			po_reg <= 1'b0;
			wsel_reg <= WSEL_RST;
			baud_reg <= BAUD_RST;
		end else begin
			if (wr_ctrl && wstrb_reg[1]) en_reg <= ctrl_wd[FLD_ENABLE];
			if (wr_ctrl && !en_reg && wstrb_reg[0]) begin
				wsel_reg <= ctrl_wd[FLD_WSEL_MSB:FLD_WSEL_LSB];
				msb_reg <= ctrl_wd[FLD_MSB_FIRST];
				ph_reg <= ctrl_wd[FLD_EDGE_SEL];
				po_reg <= ctrl_wd[FLD_IDLE_LVL];
				ms_reg <= ctrl_wd[FLD_MASTER];
			end
			if (wr_baud && !en_reg) baud_reg <= merge(baud_reg, wdata_reg, wstrb_reg); // see (RULE18)
		end
	end

	// Transmit buffer; a write in the take cycle keeps it full
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tb_reg <= 16'h0000;
			tb_full_reg <= 1'b0;
			tb_full_d_reg <= 1'b0;
		end else begin
			if (wr_tx) begin
				tb_reg <= merge(tb_reg, wdata_reg, wstrb_reg);
				tb_full_reg <= 1'b1;
			end else if (load) begin
				tb_full_reg <= 1'b0;
			end
			tb_full_d_reg <= tb_full_reg && !load && !wr_tx; // see (RULE12)
		end
	end

	// AXI read path; reading the receive buffer empties it
	logic rd_take, rd_rx;
	assign rd_take = i_s_axi_arvalid && o_s_axi_arready;
	assign rd_rx = rd_take && ({i_s_axi_araddr[7:2], 2'b00} == ADDR_RX);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rb_reg <= 16'h0000;
			rb_full_reg <= 1'b0;
		end else if (done) begin
			rb_reg <= rx_align; // see (RULE9) (RULE16)
			rb_full_reg <= 1'b1;
		end else if (rd_rx) begin
			rb_full_reg <= 1'b0;
		end
	end

	logic [15:0] rd_ctrl, rd_stat, rd_val;
	logic rd_hit;
	always_comb begin
		rd_ctrl = 16'h0000;
		rd_stat = 16'h0000;
		rd_ctrl[FLD_ENABLE] = en_reg;
		if (en_reg) begin // see (RULE5)
			rd_ctrl[FLD_CNT_MSB:FLD_CNT_LSB] = cnt_reg[3:0];
			rd_ctrl[FLD_ERR_TX] = err_tx_reg;
			rd_ctrl[FLD_ERR_RX] = err_rx_reg;
			rd_ctrl[FLD_ERR_PH] = err_ph_reg;
			rd_ctrl[FLD_ERR_BD] = err_bd_reg;
			rd_ctrl[FLD_BUSY] = busy_reg;
		end else begin
			rd_ctrl[FLD_WSEL_MSB:FLD_WSEL_LSB] = wsel_reg;
			rd_ctrl[FLD_MSB_FIRST] = msb_reg;
			rd_ctrl[FLD_EDGE_SEL] = ph_reg;
			rd_ctrl[FLD_IDLE_LVL] = po_reg;
			rd_ctrl[FLD_MASTER] = ms_reg;
		end
		rd_stat[FLD_TB_FULL] = tb_full_reg;
		rd_stat[FLD_RB_FULL] = rb_full_reg;
		rd_stat[FLD_ST_BUSY] = busy_reg;
		rd_hit = 1'b1;
		unique case ({i_s_axi_araddr[7:2], 2'b00})
			ADDR_CTRL: rd_val = rd_ctrl;
			ADDR_BAUD: rd_val = baud_reg;
			ADDR_TX: rd_val = tb_reg;
			ADDR_RX: rd_val = rb_reg;
			ADDR_STAT: rd_val = rd_stat;
			default: begin
				rd_val = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h00000000;
			o_s_axi_rresp <= RESP_OKAY;
		end else if (rd_take) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata <= {16'h0000, rd_val};
			o_s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (i_s_axi_rready) o_s_axi_rvalid <= 1'b0;
			o_s_axi_arready <= !o_s_axi_rvalid;
		end
	end

	// Edge history for slave edge detection and timing checks
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sck_prev_reg <= 1'b0;
			din_prev_reg <= 1'b0;
			edge_d_reg <= 1'b0;
		end else begin
			sck_prev_reg <= s_sck;
			din_prev_reg <= din;
			edge_d_reg <= s_edge;
		end
	end

	// Error flags, W1C through the status view; a new event wins over the clear
	logic clr_ok;
	assign clr_ok = wr_ctrl && en_reg && wstrb_reg[1];
	logic ev_rx_err, ev_ph_err, ev_bd_err;
	assign ev_rx_err = done && rb_full_reg && !rd_rx;
	assign ev_ph_err = !ms_reg && act && latch_evt && (din != din_prev_reg);
	assign ev_bd_err = s_edge && edge_d_reg;
	always_ff @(posedge i_core_clk or posedge i_rst) begin // see (RULE21)
		if (i_rst) begin
			err_tx_reg <= 1'b0;
			err_rx_reg <= 1'b0;
			err_ph_reg <= 1'b0;
			err_bd_reg <= 1'b0;
		end else begin
			err_tx_reg <= tx_err_evt || (err_tx_reg && !(clr_ok && ctrl_wd[FLD_ERR_TX]));
			err_rx_reg <= ev_rx_err || (err_rx_reg && !(clr_ok && ctrl_wd[FLD_ERR_RX]));
			err_ph_reg <= ev_ph_err || (err_ph_reg && !(clr_ok && ctrl_wd[FLD_ERR_PH]));
			err_bd_reg <= ev_bd_err || (err_bd_reg && !(clr_ok && ctrl_wd[FLD_ERR_BD]));
		end
	end

	// Shift engine
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= SSP_IDLE;
			sr_reg <= 16'h0000;
			rx_reg <= 16'h0000;
			cnt_reg <= 5'h00;
			sck_reg <= 1'b0;
			out_reg <= 1'b0;
			pre_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else if (!en_reg) begin
			// Clock rests at its idle level before the pin driver turns on
			state_reg <= SSP_IDLE;
			cnt_reg <= 5'h00;
			sck_reg <= po_reg;
			pre_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			if (m_edge) sck_reg <= ~sck_reg;
			if (act && latch_evt) begin
				rx_reg <= rx_in;
				cnt_reg <= cnt_reg + 5'h01; // see (RULE14)
			end
			if (act && shift_evt && !done) begin
				if (pre_reg) begin
					pre_reg <= 1'b0;
				end else begin
					out_reg <= first_bit(sr_reg, msb_reg, wlen);
					sr_reg <= shift_tx(sr_reg, msb_reg);
				end
			end
			// First bit goes out on load; leading-edge shifting skips its first edge
			if (load) begin
				out_reg <= first_bit(tb_reg, msb_reg, wlen); // see (RULE23)
				sr_reg <= shift_tx(tb_reg, msb_reg);
				pre_reg <= ph_reg;
			end
			unique case (state_reg)
				SSP_IDLE: begin
					if (start_s) begin
						state_reg <= SSP_SHIFT;
						busy_reg <= 1'b1;
					end else if (load) begin
						state_reg <= ms_reg ? SSP_SHIFT : SSP_LOADED; // see (RULE7)
						busy_reg <= ms_reg; // see (RULE8)
					end
				end
				SSP_LOADED: begin
					if (start_s) begin
						state_reg <= SSP_SHIFT;
						busy_reg <= 1'b1; // see (RULE8)
					end
				end
				SSP_SHIFT: begin
					if (done) begin
						cnt_reg <= 5'h00;
						// Reloaded word continues with no gap
						if (!load) begin // see (RULE22)
							state_reg <= SSP_IDLE;
							busy_reg <= 1'b0; // see (RULE10) (RULE11)
						end
					end
				end
				default: begin
					state_reg <= SSP_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	// Pin enables and event pulses
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_master_out_line_oe <= 1'b0;
			o_master_in_line_oe <= 1'b0;
			o_master_shift_clock_out_oe <= 1'b0;
			o_tx_empty_irq <= 1'b0;
			o_rx_full_irq <= 1'b0;
			o_err_irq <= 1'b0;
			o_xfer_done_irq <= 1'b0;
		end else begin
			o_master_out_line_oe <= en_reg && ms_reg;
			o_master_in_line_oe <= en_reg && !ms_reg;
			o_master_shift_clock_out_oe <= en_reg && ms_reg; // see (RULE19)
			o_tx_empty_irq <= en_reg && tx_empty_evt; // see (RULE8)
			o_rx_full_irq <= en_reg && done; // see (RULE9)
			o_err_irq <= en_reg && (tx_err_evt || ev_rx_err || ev_ph_err || ev_bd_err); // see (RULE21)
			o_xfer_done_irq <= en_reg && done && !load;
		end
	end

	assign o_master_out_line = out_reg;
	assign o_master_in_line = out_reg;
	assign o_master_shift_clock_out = sck_reg;
endmodule // ssp_port
`default_nettype wire

// ===== testbench/ssp_far_model.sv
// Far-side shift device answering the port in master mode
`timescale 1ns/10ps
`default_nettype none
module ssp_far_model (
	// Frame set-up
	input wire logic i_load,
	input wire logic [15:0] i_word,
	input wire logic i_idle,
	input wire logic i_edge,
	input wire logic i_msb,
	input wire logic [4:0] i_width,
	// Link
	input wire logic i_sclk,
	input wire logic i_mosi,
	output logic o_miso,
	output logic [15:0] o_got
);
	int sh = 0;
	int lt = 99;
	logic first = 1'b0;
	function automatic int pos(input int k);
		return i_msb ? int'(i_width) - 1 - k : k;
	endfunction
	initial o_miso = 1'b0;
	initial o_got = 16'h0000;
	always @(posedge i_load) begin
		sh = 0;
		lt = 0;
		first = 1'b1;
		o_got = 16'h0000;
		o_miso = i_word[pos(0)];
	end
	// Clock is input only; disarmed outside a frame so enable glitches are ignored
	always @(i_sclk) begin
		if (!i_load && lt < int'(i_width)) begin
			if ((i_sclk != i_idle) != i_edge) begin
				o_got[pos(lt)] = i_mosi;
				lt++;
				if (lt == int'(i_width)) o_miso = ~o_miso;
			end else if (first && i_edge) begin
				first = 1'b0;
			end else begin
				sh++;
				o_miso = i_word[pos(sh)];
			end
		end
	end
endmodule // ssp_far_model
`default_nettype wire

// ===== testbench/ssp_port_properties.sv
// Checker on the serial shift port top-level ports
`timescale 1ns/10ps
`default_nettype none
module ssp_port_properties
	import ssp_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register bus
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic o_s_axi_rvalid,
	input wire logic [31:0] o_s_axi_rdata,
	// Link enables and events
	input wire logic o_master_out_line_oe,
	input wire logic o_master_in_line_oe,
	input wire logic o_master_shift_clock_out_oe,
	input wire logic o_tx_empty_irq,
	input wire logic o_rx_full_irq,
	input wire logic o_xfer_done_irq
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_start;
		o_tx_empty_irq;
	endsequence
	sequence s_quiet;
		!o_rx_full_irq [*3];
	endsequence
	sequence s_tx_write;
		i_s_axi_awvalid && o_s_axi_awready && i_s_axi_awaddr[7:2] == ADDR_TX[7:2];
	endsequence
	property p_frame_len;
		s_start |=> s_quiet;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("receive buffer loaded too soon after start");
	property p_tx_pulse;
		o_tx_empty_irq |=> !o_tx_empty_irq;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("transmit empty pulse too long");
	property p_rx_pulse;
		o_rx_full_irq |=> !o_rx_full_irq;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("receive full pulse too long");
	property p_done;
		o_xfer_done_irq |-> o_rx_full_irq;
	endproperty
	a_done: assert property (p_done)
		else $error("busy cleared apart from receive load");
	property p_start_gap;
		s_tx_write |-> !o_tx_empty_irq ##1 !o_tx_empty_irq;
	endproperty
	a_start_gap: assert property (p_start_gap)
		else $error("transfer started too soon after write");
	property p_one_driver;
		o_master_shift_clock_out_oe |-> !o_master_in_line_oe;
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("master drives its own input line");
	property p_oe_pair;
		o_master_out_line_oe == o_master_shift_clock_out_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair)
		else $error("clock and data enables disagree");
	property p_rdata_hi;
		o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_rdata_hi: assert property (p_rdata_hi)
		else $error("upper read data not zero");
endmodule // ssp_port_properties
`default_nettype wire

// ===== testbench/ssp_port_tb_top.sv
// Self-checking bench for the serial shift port
`timescale 1ns/10ps
`default_nettype none
module ssp_port_tb_top;
	import ssp_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_s_axi_awaddr = 8'h00;
	logic [7:0] i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0;
	logic [3:0] i_s_axi_wstrb = 4'h0;
	logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
	logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic [31:0] o_s_axi_rdata;
	logic i_master_out_line = 0, i_shift_clock_pin = 0, i_master_in_line;
	logic o_master_out_line, o_master_out_line_oe, o_master_in_line, o_master_in_line_oe;
	logic o_master_shift_clock_out, o_master_shift_clock_out_oe;
	logic o_tx_empty_irq, o_rx_full_irq, o_err_irq, o_xfer_done_irq;
	logic f_load = 0, f_idle = 0, f_edge = 0, f_msb = 0, f_miso;
	logic [4:0] f_width = 5'h08;
	logic [15:0] f_word = 16'h0000;
	logic [15:0] f_got;
	int fail_count = 0, comparisons = 0, cycles = 0, rx_cnt = 0, done_cnt = 0, err_cnt = 0;
	// Undriven wires show the inverse level
	assign i_master_in_line = o_master_in_line_oe ? o_master_in_line : f_miso;
	ssp_port u_ssp_port (.i_core_clk, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
		.o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
		.o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_master_out_line,
		.o_master_out_line, .o_master_out_line_oe, .i_master_in_line, .o_master_in_line,
		.o_master_in_line_oe, .i_shift_clock_pin, .o_master_shift_clock_out,
		.o_master_shift_clock_out_oe, .o_tx_empty_irq, .o_rx_full_irq, .o_err_irq, .o_xfer_done_irq);
	ssp_far_model u_ssp_far_model (.i_load(f_load), .i_word(f_word), .i_idle(f_idle),
		.i_edge(f_edge), .i_msb(f_msb), .i_width(f_width), .o_miso(f_miso), .o_got(f_got),
		.i_sclk(o_master_shift_clock_out_oe ? o_master_shift_clock_out : ~o_master_shift_clock_out),
		.i_mosi(o_master_out_line_oe ? o_master_out_line : ~o_master_out_line));
	always #10 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cycles++;
		rx_cnt += int'(o_rx_full_irq === 1'b1);
		done_cnt += int'(o_xfer_done_irq === 1'b1);
		err_cnt += int'(o_err_irq === 1'b1);
		if (cycles == 40000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		@(posedge i_core_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= {16'h0000, d};
		i_s_axi_wstrb <= 4'h3;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		do begin
			@(posedge i_core_clk);
			if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
			if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
		end while (o_s_axi_bvalid !== 1'b1);
		r = o_s_axi_bresp;
		i_s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_core_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		do begin
			@(posedge i_core_clk);
			if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
		end while (o_s_axi_rvalid !== 1'b1);
		d = o_s_axi_rdata;
		r = o_s_axi_rresp;
		i_s_axi_rready <= 1'b0;
	endtask
	task automatic t_reset;
		logic [31:0] v;
		logic [1:0] r;
		rd(ADDR_CTRL, v, r);
		check("ctrl reset", v, 32'h0000_0007);
		rd(ADDR_BAUD, v, r);
		check("baud reset", v, 32'h0000_0009);
		rd(8'h14, v, r);
		check("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
		wr(8'h14, 16'hFFFF, r);
		check("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
		$display("test reset done");
	endtask
	// Every polarity, phase and order; widths 2, 8 and 16
	task automatic t_modes;
		logic [31:0] v;
		logic [1:0] r;
		logic [15:0] cfg, tx, m;
		int w, k, d;
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? 2 : (i == 7) ? 16 : 8;
			m = 16'((17'h1 << w) - 17'h1);
			tx = 16'hC3A6 ^ 16'(i);
			cfg = {8'h00, 1'b1, i[0], i[1], i[2], 4'(w - 1)};
			f_idle <= i[0];
			f_edge <= i[1];
			f_msb <= i[2];
			f_width <= 5'(w);
			f_word <= 16'h5B1E ^ 16'(i << 8);
			wr(ADDR_CTRL, cfg, r);
			wr(ADDR_CTRL, cfg | 16'h8000, r);
			repeat (2) @(posedge i_core_clk);
			check("idle clock", 32'(o_master_shift_clock_out), 32'(i[0]));
			f_load <= 1'b1;
			@(posedge i_core_clk);
			f_load <= 1'b0;
			k = rx_cnt + 1;
			d = done_cnt + 1;
			wr(ADDR_TX, tx, r);
			while (rx_cnt < k) @(posedge i_core_clk);
			rd(ADDR_RX, v, r);
			check("rx word", v & 32'(m), 32'(f_word & m));
			check("far word", 32'(f_got), 32'(tx & m));
			check("done pulses", 32'(done_cnt), 32'(d));
			check("held line", 32'(o_master_out_line), 32'(i[2] ? tx[0] : tx[w - 1]));
			wr(ADDR_CTRL, cfg, r);
		end
		$display("test modes done");
	endtask
	// Two frames back to back read as one 16-bit frame by the far side
	task automatic t_stream;
		logic [31:0] v;
		logic [1:0] r;
		int k, d;
		f_idle <= 1'b0;
		f_edge <= 1'b0;
		f_msb <= 1'b1;
		f_width <= 5'h10;
		f_word <= 16'h96E1;
		wr(ADDR_CTRL, 16'h0097, r);
		wr(ADDR_CTRL, 16'h8097, r);
		f_load <= 1'b1;
		@(posedge i_core_clk);
		f_load <= 1'b0;
		k = rx_cnt;
		d = done_cnt;
		wr(ADDR_TX, 16'h00A7, r);
		do @(posedge i_core_clk); while (o_tx_empty_irq !== 1'b1);
		wr(ADDR_TX, 16'h005C, r);
		rd(ADDR_CTRL, v, r);
		check("status view", v & 32'h9000, 32'h9000);
		while (rx_cnt < k + 1) @(posedge i_core_clk);
		rd(ADDR_RX, v, r);
		check("first rx", v & 32'hFF, 32'h96);
		while (rx_cnt < k + 2) @(posedge i_core_clk);
		rd(ADDR_RX, v, r);
		check("second rx", v & 32'hFF, 32'hE1);
		check("joined frame", 32'(f_got), 32'hA75C);
		check("one done pulse", 32'(done_cnt), 32'(d + 1));
		check("no error pulses", 32'(err_cnt), 32'h0);
		wr(ADDR_CTRL, 16'h0097, r);
		$display("test stream done");
	endtask
	initial begin
		repeat (12) @(posedge i_core_clk);
		i_rst <= 1'b0;
		t_reset();
		t_modes();
		t_stream();
		complete_run();
	end
endmodule // ssp_port_tb_top
bind ssp_port ssp_port_properties u_ssp_port_properties (.i_core_clk, .i_rst, .i_s_axi_awaddr,
	.i_s_axi_awvalid, .o_s_axi_awready, .o_s_axi_rvalid, .o_s_axi_rdata, .o_master_out_line_oe,
	.o_master_in_line_oe, .o_master_shift_clock_out_oe, .o_tx_empty_irq, .o_rx_full_irq,
	.o_xfer_done_irq);
`default_nettype wire
